/* shared/slmc_defs.vh */
// Purpose: Constants for the sleep mode controller
// Assumes: Included once by each design file that needs it
// Notes: Mode codes are written by software into the mode field
// Functional notes
// RQ1 - Six power saving modes exist and software picks one before sleeping.
// RQ2 - Light sleep stops only the CPU clock; SRAM, timers, serial port and interrupts run.
// RQ3 - Deepest sleep stops the oscillator and all functions until interrupt or reset.
// RQ4 - Timer-keepalive sleep keeps the asynchronous timer running.
// RQ5 - Converter-quiet sleep stops CPU and I/O except asynchronous timer and converter.
// RQ6 - Oscillator-standby sleep keeps the main oscillator running while all else sleeps.
// RQ7 - Extended standby keeps main oscillator and asynchronous timer running.
// RQ8 - Software sets the mode field before the request; sleep keeps all register state.
`ifndef SLMC_DEFS_VH
`define SLMC_DEFS_VH

`define SLMC_MODE_W 3
`define SLMC_MODE_IDLE 3'h0
`define SLMC_MODE_ADCQ 3'h1
`define SLMC_MODE_PDOWN 3'h2
`define SLMC_MODE_PSAVE 3'h3
`define SLMC_MODE_STBY 3'h6
`define SLMC_MODE_XSTBY 3'h7
`define SLMC_MODE_RESET 3'h0

// Clock-enable vector bit positions
`define SLMC_DOM_W 8
`define SLMC_DOM_CPU 0
`define SLMC_DOM_SRAM 1
`define SLMC_DOM_TMR 2
`define SLMC_DOM_SER 3
`define SLMC_DOM_IRQ 4
`define SLMC_DOM_IO 5
`define SLMC_DOM_ADC 6
`define SLMC_DOM_ATMR 7
`define SLMC_DOM_ALL 8'hff

`endif

/* rtl/slmc_sync.v */
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Single destination clock
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module slmc_sync #(
    parameter WIDTH = 1
) (
    ref_clk,
    reset,
    asyncIn,
    syncOut
);
    input wire ref_clk;
    input wire reset;
    input wire [WIDTH-1:0] asyncIn;
    output reg [WIDTH-1:0] syncOut;

    reg [WIDTH-1:0] meta_q;

    always @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

/* rtl/slmc_sleep_ctrl.v */
// Purpose: Sleep mode controller gating per-domain clocks and the main oscillator
// Assumes: sleepReq, mode fields from CPU logic on ref_clk; wakeIrq async from pins
// Notes: Domain enables and oscillator enables are registered outputs
// Notes: Reserved mode codes raise a one-cycle error and never sleep
`timescale 1ns/10ps
`include "slmc_defs.vh"
module slmc_sleep_ctrl (
    ref_clk,
    reset,
    sleepEnable,
    sleepMode,
    sleepReq,
    wakeIrq,
    clkEnable,
    mainOscEnable,
    asleep,
    activeMode,
    modeError
);
    input wire ref_clk;
    input wire reset;
    input wire sleepEnable;
    input wire [`SLMC_MODE_W-1:0] sleepMode;
    input wire sleepReq;
    input wire wakeIrq;
    output reg [`SLMC_DOM_W-1:0] clkEnable;
    output reg mainOscEnable;
    output reg asleep;
    output reg [`SLMC_MODE_W-1:0] activeMode;
    output reg modeError;

    localparam ST_RUN = 1'b0;
    localparam ST_SLEEP = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Domain map per mode; the top bit is the main oscillator
    function [`SLMC_DOM_W:0] domainMap;
        input [`SLMC_MODE_W-1:0] m;
        reg [`SLMC_DOM_W-1:0] dom;
        reg osc;
        begin
            dom = `SLMC_DOM_ALL;
            osc = 1'b1;
            case (m)
                `SLMC_MODE_IDLE: begin // RQ2
                    dom[`SLMC_DOM_CPU] = 1'b0;
                    dom[`SLMC_DOM_SRAM] = 1'b1;
                    dom[`SLMC_DOM_TMR] = 1'b1;
                    dom[`SLMC_DOM_SER] = 1'b1;
                    dom[`SLMC_DOM_IRQ] = 1'b1;
                    dom[`SLMC_DOM_IO] = 1'b1;
                    dom[`SLMC_DOM_ADC] = 1'b1;
                    dom[`SLMC_DOM_ATMR] = 1'b1;
                    osc = 1'b1;
                end
                `SLMC_MODE_ADCQ: begin // RQ5
                    dom[`SLMC_DOM_CPU] = 1'b0;
                    dom[`SLMC_DOM_SRAM] = 1'b1;
                    dom[`SLMC_DOM_TMR] = 1'b0;
                    dom[`SLMC_DOM_SER] = 1'b0;
                    dom[`SLMC_DOM_IRQ] = 1'b1;
                    dom[`SLMC_DOM_IO] = 1'b0;
                    dom[`SLMC_DOM_ADC] = 1'b1;
                    dom[`SLMC_DOM_ATMR] = 1'b1;
                    osc = 1'b1;
                end
                `SLMC_MODE_PDOWN: begin // RQ3
                    // Only the wake pin or a reset ends this mode
                    dom[`SLMC_DOM_CPU] = 1'b0;
                    dom[`SLMC_DOM_SRAM] = 1'b0;
                    dom[`SLMC_DOM_TMR] = 1'b0;
                    dom[`SLMC_DOM_SER] = 1'b0;
                    dom[`SLMC_DOM_IRQ] = 1'b0;
                    dom[`SLMC_DOM_IO] = 1'b0;
                    dom[`SLMC_DOM_ADC] = 1'b0;
                    dom[`SLMC_DOM_ATMR] = 1'b0;
                    osc = 1'b0;
                end
                `SLMC_MODE_PSAVE: begin // RQ4
                    // Interrupt logic kept so the timer can wake the core
                    dom[`SLMC_DOM_CPU] = 1'b0;
                    dom[`SLMC_DOM_SRAM] = 1'b0;
                    dom[`SLMC_DOM_TMR] = 1'b0;
                    dom[`SLMC_DOM_SER] = 1'b0;
                    dom[`SLMC_DOM_IRQ] = 1'b1;
                    dom[`SLMC_DOM_IO] = 1'b0;
                    dom[`SLMC_DOM_ADC] = 1'b0;
                    dom[`SLMC_DOM_ATMR] = 1'b1;
                    osc = 1'b0;
                end
                `SLMC_MODE_STBY: begin // RQ6
                    // Oscillator stays up for a fast start
                    dom[`SLMC_DOM_CPU] = 1'b0;
                    dom[`SLMC_DOM_SRAM] = 1'b0;
                    dom[`SLMC_DOM_TMR] = 1'b0;
                    dom[`SLMC_DOM_SER] = 1'b0;
                    dom[`SLMC_DOM_IRQ] = 1'b0;
                    dom[`SLMC_DOM_IO] = 1'b0;
                    dom[`SLMC_DOM_ADC] = 1'b0;
                    dom[`SLMC_DOM_ATMR] = 1'b0;
                    osc = 1'b1;
                end
                `SLMC_MODE_XSTBY: begin // RQ7
                    dom[`SLMC_DOM_CPU] = 1'b0;
                    dom[`SLMC_DOM_SRAM] = 1'b0;
                    dom[`SLMC_DOM_TMR] = 1'b0;
                    dom[`SLMC_DOM_SER] = 1'b0;
                    dom[`SLMC_DOM_IRQ] = 1'b1;
                    dom[`SLMC_DOM_IO] = 1'b0;
                    dom[`SLMC_DOM_ADC] = 1'b0;
                    dom[`SLMC_DOM_ATMR] = 1'b1;
                    osc = 1'b1;
                end
                default: begin
                    dom = `SLMC_DOM_ALL;
                    osc = 1'b1;
                end
            endcase
            domainMap = {osc, dom};
        end
    endfunction

    function legalMode;
        input [`SLMC_MODE_W-1:0] m;
        begin
            case (m)
                `SLMC_MODE_IDLE: legalMode = 1'b1;
                `SLMC_MODE_ADCQ: legalMode = 1'b1;
                `SLMC_MODE_PDOWN: legalMode = 1'b1;
                `SLMC_MODE_PSAVE: legalMode = 1'b1;
                `SLMC_MODE_STBY: legalMode = 1'b1;
                `SLMC_MODE_XSTBY: legalMode = 1'b1;
                // Codes 4 and 5 are reserved
                default: legalMode = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Wake input comes from pins, so synchronise it
    wire wakeSync;

    slmc_sync #(.WIDTH(1)) uWakeSync (
        .ref_clk(ref_clk),
        .reset(reset),
        .asyncIn(wakeIrq),
        .syncOut(wakeSync)
    );

    reg state_q;
    reg state_d;
    reg [`SLMC_MODE_W-1:0] mode_q;
    reg [`SLMC_MODE_W-1:0] mode_d;
    reg [`SLMC_DOM_W:0] map;

    wire reqSeen;
    wire modeOk;
    wire takeReq;
    wire refuseReq;

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification shared by entry and refusal
    assign reqSeen = sleepReq && sleepEnable && (state_q == ST_RUN);
    assign modeOk = legalMode(sleepMode);
    // A pending wake beats a new request, so no interrupt is slept through
    assign takeReq = reqSeen && modeOk && !wakeSync;
    // Reserved codes are refused and flagged, never half-entered
    assign refuseReq = reqSeen && !modeOk;

    ////////////////////////////////////////////////////////////////////////////
    // Next state; the mode field is sampled only when a request is taken
    always @* begin
        state_d = state_q;
        mode_d = mode_q;
        case (state_q)
            ST_RUN: begin
                if (takeReq) begin
                    state_d = ST_SLEEP; // RQ1
                    mode_d = sleepMode; // RQ8
                end
            end
            ST_SLEEP: begin
                // Interrupt ends any mode; reset handled below
                if (wakeSync) begin
                    state_d = ST_RUN; // RQ3
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enables of the coming cycle; all on while running
    always @* begin
        if (state_d == ST_SLEEP) begin
            map = domainMap(mode_d);
        end else begin
            map = {1'b1, `SLMC_DOM_ALL};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only enables are gated; no state is cleared on entry or exit
    always @(posedge ref_clk) begin // RQ8
        if (reset) begin
            state_q <= ST_RUN;
            mode_q <= `SLMC_MODE_RESET;
            clkEnable <= `SLMC_DOM_ALL;
            mainOscEnable <= 1'b1;
            asleep <= 1'b0;
            activeMode <= `SLMC_MODE_RESET;
            modeError <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            clkEnable <= map[`SLMC_DOM_W-1:0];
            mainOscEnable <= map[`SLMC_DOM_W];
            asleep <= state_d;
            activeMode <= mode_d;
            modeError <= refuseReq;
        end
    end
endmodule

/* tb/slmc_chk.sv */
// Purpose: Port checks of the sleep controller
// Assumes: Wake input crosses two flops
// Notes: Domain maps as settled by the designer
`timescale 1ns/10ps
module slmc_chk(input wire ref_clk, reset, sleepEnable, sleepReq, wakeIrq, mainOscEnable,
    asleep, modeError, input wire [2:0] sleepMode, activeMode, input wire [7:0] clkEnable);
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
// Wake pending only shows two edges late
sequence take; sleepReq && sleepEnable && !asleep && !$past(wakeIrq, 2); endsequence
property map(m, c, o); $rose(asleep) && activeMode == m |-> clkEnable == c && mainOscEnable == o;
endproperty
AST_ENTER: assert property (take ##0 (sleepMode != 3'h4 && sleepMode != 3'h5)
    |=> asleep && activeMode == $past(sleepMode)) else $error("sleep entry wrong");
AST_REFUSE: assert property (take ##0 (sleepMode == 3'h4 || sleepMode == 3'h5)
    |=> modeError && !asleep) else $error("reserved mode taken");
AST_IDLE: assert property (map(3'h0, 8'hfe, 1'b1)) else $error("idle map");
AST_ADCQ: assert property (map(3'h1, 8'hd2, 1'b1)) else $error("adc quiet map");
AST_PDOWN: assert property (map(3'h2, 8'h00, 1'b0)) else $error("power down map");
AST_PSAVE: assert property (map(3'h3, 8'h90, 1'b0)) else $error("power save map");
AST_STBY: assert property (map(3'h6, 8'h00, 1'b1)) else $error("standby map");
AST_XSTBY: assert property (map(3'h7, 8'h90, 1'b1)) else $error("ext standby map");
AST_HOLD: assert property (asleep && !$past(wakeIrq, 2) |=> asleep && $stable(clkEnable))
    else $error("sleep not held");
AST_WAKE: assert property (asleep && $past(wakeIrq, 2)
    |=> !asleep && clkEnable == 8'hff && mainOscEnable) else $error("wake wrong");
endmodule

/* tb/slmc_cpu_model.sv */
// Purpose: CPU and interrupt side of the sleep controller
// Assumes: Drives on rising edges only
// Notes: Request is a one-cycle pulse
`timescale 1ns/10ps
module slmc_cpu_model(input wire ref_clk, output reg sleepEnable, output reg [2:0] sleepMode,
    output reg sleepReq, output reg wakeIrq);
initial {sleepEnable, sleepMode, sleepReq, wakeIrq} = 6'h00;
task req(input [2:0] m, input e);
    begin
        @(posedge ref_clk);
        sleepMode <= m;
        sleepEnable <= e;
        @(posedge ref_clk);
        sleepReq <= 1'b1;
        @(posedge ref_clk);
        sleepReq <= 1'b0;
    end
endtask
task irq(input v);
    begin
        @(posedge ref_clk);
        wakeIrq <= v;
    end
endtask
endmodule

/* tb/slmc_sleep_ctrl_tb_top.sv */
// Purpose: Self-checking bench of the sleep controller
// Assumes: Request model drives the inputs
// Notes: Status is error, asleep, oscillator, domains
`timescale 1ns/10ps
module slmc_sleep_ctrl_tb_top;
reg ref_clk = 0, reset = 1;
wire sleepEnable, sleepReq, wakeIrq, mainOscEnable, asleep, modeError;
wire [2:0] sleepMode, activeMode;
wire [7:0] clkEnable;
wire [10:0] st = {modeError, asleep, mainOscEnable, clkEnable};
integer n_fail = 0, n_checks = 0;
slmc_cpu_model i_slmc_cpu_model(.ref_clk, .sleepEnable, .sleepMode, .sleepReq, .wakeIrq);
slmc_sleep_ctrl i_slmc_sleep_ctrl(.ref_clk, .reset, .sleepEnable, .sleepMode, .sleepReq,
    .wakeIrq, .clkEnable, .mainOscEnable, .asleep, .activeMode, .modeError);
initial forever #5 ref_clk = ~ref_clk;
task check(input [10:0] seen, input [10:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t status %h expected %h", $time, seen, exp);
        end
    end
endtask
task final_report;
    begin
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    end
endtask
task wake;
    integer i;
    begin
        i_slmc_cpu_model.irq(1'b1);
        for (i = 0; i < 8 && asleep !== 1'b0; i = i + 1) begin
            @(posedge ref_clk);
            #1;
        end
        if (i == 8) begin
            n_fail = n_fail + 1;
            final_report;
        end
        check(st, 11'h1ff);
        i_slmc_cpu_model.irq(1'b0);
        // Let the synchroniser drain before the next request
        repeat (3) @(posedge ref_clk);
    end
endtask
task run(input [2:0] m, input [8:0] exp);
    begin
        i_slmc_cpu_model.req(m, 1'b1);
        #1 check(st, {2'b01, exp});
        check({8'h00, activeMode}, {8'h00, m});
        repeat (4) @(posedge ref_clk);
        #1 check(st, {2'b01, exp});
        wake;
    end
endtask
task hw_reset;
    begin
        i_slmc_cpu_model.req(3'h2, 1'b1);
        #1 check(st, 11'h200);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1 check(st, 11'h1ff);
        check({8'h00, activeMode}, 11'h000);
    end
endtask
task busy;
    begin
        i_slmc_cpu_model.irq(1'b1);
        i_slmc_cpu_model.req(3'h0, 1'b1);
        #1 check(st, 11'h1ff);
        i_slmc_cpu_model.irq(1'b0);
        repeat (3) @(posedge ref_clk);
    end
endtask
task refuse;
    integer m;
    begin
        for (m = 4; m < 6; m = m + 1) begin
            i_slmc_cpu_model.req(m[2:0], 1'b1);
            #1 check(st, 11'h5ff);
        end
        i_slmc_cpu_model.req(3'h2, 1'b0);
        #1 check(st, 11'h1ff);
    end
endtask
initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1 check(st, 11'h1ff);
    run(3'h0, 9'h1fe);
    run(3'h1, 9'h1d2);
    run(3'h2, 9'h000);
    run(3'h3, 9'h090);
    run(3'h6, 9'h100);
    run(3'h7, 9'h190);
    hw_reset;
    busy;
    refuse;
    final_report;
end
endmodule
bind slmc_sleep_ctrl slmc_chk i_slmc_chk(.ref_clk, .reset, .sleepEnable, .sleepReq, .wakeIrq,
    .mainOscEnable, .asleep, .modeError, .sleepMode, .activeMode, .clkEnable);
